// file: urx_line_status.sv
`timescale 1ns/1ps
module urx_line_status
    import urx_pkg::*;
#(
    parameter int FIFO_DEPTH = 16
) (
    // Clock and reset
    input  wire logic              clock,
    input  wire logic              nrst,
    // Register port
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic [REG_W-1:0]  wdata,
    input  wire logic              wr_stb,
    input  wire logic              rd_stb,
    output logic      [REG_W-1:0]  rdata,
    // Receive line
    input  wire logic              serial_in,
    input  wire logic              ir_in,
    // Interrupt
    output logic                   irq
);
    localparam int PTR_W = $clog2(FIFO_DEPTH);
    localparam int CNT_W = $clog2(FIFO_DEPTH + 1);
    localparam logic [CNT_W-1:0] DEPTH_C = CNT_W'(FIFO_DEPTH);
    localparam logic [CNT_W-1:0] ONE_C   = CNT_W'(1);

    logic             sin_q;
    logic             ir_q;
    logic [CT_W-1:0]  ctrl_reg;
    logic [15:0]      div_reg;
    logic [15:0]      div_cnt_reg;
    logic             tick_reg;
    logic [4:0]       ir_hold_reg;
    logic [7:0]       low_cnt_reg;
    urx_state_t       state_reg;
    logic [3:0]       os_reg;
    logic [2:0]       idx_reg;
    logic [7:0]       shift_reg;
    logic             par_bit_reg;
    logic             ld_reg;
    logic [7:0]       ld_data_reg;
    logic             ld_brk_reg;
    logic             ld_fe_reg;
    logic             ld_pe_reg;
    logic [7:0]       data_mem [FIFO_DEPTH];
    logic [2:0]       flag_mem [FIFO_DEPTH];
    logic [PTR_W-1:0] wr_ptr_reg;
    logic [PTR_W-1:0] rd_ptr_reg;
    logic [CNT_W-1:0] count_reg;
    logic             head_new_reg;
    logic             brk_reg;
    logic             fe_reg;
    logic             pe_reg;
    logic             oe_reg;
    logic [INT_W-1:0] int_st_reg;
    logic [INT_W-1:0] int_mask_reg;

    urx_sync u_sync_sin (
        .clock (clock),
        .nrst  (nrst),
        .d     (serial_in),
        .q     (sin_q)
    );

    urx_sync u_sync_ir (
        .clock (clock),
        .nrst  (nrst),
        .d     (ir_in),
        .q     (ir_q)
    );

    // Control decode
    logic       fifo_en;
    logic       par_en;
    logic       ir_mode;
    logic [3:0] data_bits;
    logic [3:0] char_bits;
    logic [7:0] char_ticks;
    logic       line;
    logic       brk_now;

    assign fifo_en    = ctrl_reg[CT_FIFO_EN];
    assign par_en     = ctrl_reg[CT_PARITY_EN];
    assign ir_mode    = ctrl_reg[CT_IR_MODE];
    assign data_bits  = MIN_DATA_BITS
                      + {2'h0, ctrl_reg[CT_DLEN_LO+1:CT_DLEN_LO]};
    assign char_bits  = data_bits + 4'h2 + {3'h0, par_en}
                      + {3'h0, ctrl_reg[CT_STOP2]};
    assign char_ticks = {char_bits, 4'h0};
    assign line       = ir_mode ? (ir_hold_reg == 5'h0) : sin_q;
    // low strictly longer than a character
    assign brk_now    = low_cnt_reg > char_ticks;

    // Bus decode
    logic wr_ctrl;
    logic pop;
    logic status_rd;
    logic flush;
    logic full;
    logic push;
    logic overwrite;
    logic overrun;

    assign wr_ctrl   = wr_stb && (addr == ADDR_CTRL);
    assign status_rd = rd_stb && (addr == ADDR_LINE_STAT);
    assign pop       = rd_stb && (addr == ADDR_RX_BUF)
                       && (count_reg != '0);
    // Mode change flushes; mixed contents would be ambiguous
    assign flush     = wr_ctrl && (wdata[CT_FIFO_EN] != fifo_en);
    assign full      = fifo_en ? (count_reg == DEPTH_C)
                               : (count_reg == ONE_C);
    assign push      = ld_reg && (!full || pop) && !flush;
    assign overwrite = ld_reg && full && !pop && !fifo_en && !flush;
    assign overrun   = ld_reg && full && !pop && !flush;

    always_ff @(posedge clock) begin
        if (!nrst) begin
            ctrl_reg     <= CTRL_RESET;
            div_reg      <= DIV_RESET;
            int_mask_reg <= '0;
        end else if (wr_stb) begin
            if (addr == ADDR_CTRL) begin
                ctrl_reg <= wdata[CT_W-1:0];
            end else if (addr == ADDR_DIVISOR) begin
                div_reg <= wdata;
            end else if (addr == ADDR_INT_MASK) begin
                int_mask_reg <= wdata[INT_W-1:0];
            end
        end
    end

    // Sixteen ticks per bit
    always_ff @(posedge clock) begin
        if (!nrst) begin
            div_cnt_reg <= '0;
            tick_reg    <= 1'b0;
        end else if (div_cnt_reg + 16'h1 >= div_reg) begin
            div_cnt_reg <= '0;
            tick_reg    <= 1'b1;
        end else begin
            div_cnt_reg <= div_cnt_reg + 16'h1;
            tick_reg    <= 1'b0;
        end
    end

    // a short pulse marks a whole zero bit
    always_ff @(posedge clock) begin
        if (!nrst) begin
            ir_hold_reg <= '0;
        end else if (!ir_q) begin
            ir_hold_reg <= IR_HOLD_TICKS;
        end else if (tick_reg && ir_hold_reg != 5'h0) begin
            ir_hold_reg <= ir_hold_reg - 5'h1;
        end
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            low_cnt_reg <= '0;
        end else if (line) begin
            low_cnt_reg <= '0;
        end else if (tick_reg && low_cnt_reg != LOW_CNT_MAX) begin
            low_cnt_reg <= low_cnt_reg + 8'h1;
        end
    end

    logic par_err;
    logic last_data;

    // parity only when enabled
    // Even mode: odd ones count is bad; odd mode: even count
    assign par_err   = par_en
                       && ((^shift_reg ^ par_bit_reg)
                           == ctrl_reg[CT_PARITY_EVEN]);
    assign last_data = ({1'b0, idx_reg} + 4'h1) == data_bits;

    always_ff @(posedge clock) begin
        if (!nrst) begin
            state_reg   <= ST_IDLE;
            os_reg      <= '0;
            idx_reg     <= '0;
            shift_reg   <= '0;
            par_bit_reg <= 1'b0;
            ld_reg      <= 1'b0;
            ld_data_reg <= '0;
            ld_brk_reg  <= 1'b0;
            ld_fe_reg   <= 1'b0;
            ld_pe_reg   <= 1'b0;
        end else begin
            ld_reg <= 1'b0;
            case (state_reg)
                ST_IDLE: begin
                    os_reg <= '0;
                    if (!line) begin
                        state_reg <= ST_START;
                    end
                end
                ST_START: begin
                    if (tick_reg) begin
                        os_reg <= os_reg + 4'h1;
                        if (os_reg == OVS_MID) begin
                            os_reg      <= '0;
                            idx_reg     <= '0;
                            shift_reg   <= '0;
                            par_bit_reg <= 1'b0;
                            state_reg   <= line ? ST_IDLE : ST_DATA;
                        end
                    end
                end
                ST_DATA: begin
                    if (tick_reg) begin
                        os_reg <= os_reg + 4'h1;
                        if (os_reg == OVS_LAST) begin
                            shift_reg[idx_reg] <= line;
                            idx_reg            <= idx_reg + 3'h1;
                            if (last_data) begin
                                state_reg <= par_en ? ST_PARITY : ST_STOP;
                            end
                        end
                    end
                end
                ST_PARITY: begin
                    if (tick_reg) begin
                        os_reg <= os_reg + 4'h1;
                        if (os_reg == OVS_LAST) begin
                            par_bit_reg <= line;
                            state_reg   <= ST_STOP;
                        end
                    end
                end
                ST_STOP: begin
                    if (tick_reg) begin
                        os_reg <= os_reg + 4'h1;
                        if (os_reg == OVS_LAST) begin
                            ld_data_reg <= shift_reg;
                            ld_brk_reg  <= 1'b0;
                            ld_pe_reg   <= par_err;
                            if (line) begin
                                ld_reg    <= 1'b1;
                                ld_fe_reg <= 1'b0;
                                state_reg <= ST_IDLE;
                            end else if (shift_reg == 8'h00
                                         && !par_bit_reg) begin
                                // All zero: may be a break, defer load
                                state_reg <= ST_HOLD;
                            end else begin
                                ld_reg      <= 1'b1;
                                ld_fe_reg   <= 1'b1;
                                // bad stop bit taken as start bit
                                idx_reg     <= '0;
                                shift_reg   <= '0;
                                par_bit_reg <= 1'b0;
                                state_reg   <= ST_DATA;
                            end
                        end
                    end
                end
                ST_HOLD: begin
                    if (line) begin
                        ld_reg    <= 1'b1;
                        ld_fe_reg <= 1'b1;
                        state_reg <= ST_IDLE;
                    end else if (brk_now) begin
                        ld_reg      <= 1'b1;
                        ld_data_reg <= 8'h00;
                        ld_brk_reg  <= 1'b1;
                        ld_fe_reg   <= 1'b1;
                        ld_pe_reg   <= 1'b1;
                        state_reg   <= ST_BRK_WAIT;
                    end
                end
                ST_BRK_WAIT: begin
                    // no new start until line idles
                    if (line) begin
                        state_reg <= ST_IDLE;
                    end
                end
                default: begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    // Receive storage; depth one in non-FIFO mode
    always_ff @(posedge clock) begin
        if (push || overwrite) begin
            data_mem[overwrite ? rd_ptr_reg : wr_ptr_reg] <= ld_data_reg;
            flag_mem[overwrite ? rd_ptr_reg : wr_ptr_reg] <=
                {ld_brk_reg, ld_fe_reg, ld_pe_reg};
        end
    end

    always_ff @(posedge clock) begin
        if (!nrst || flush) begin
            wr_ptr_reg   <= '0;
            rd_ptr_reg   <= '0;
            count_reg    <= '0;
            head_new_reg <= 1'b0;
        end else begin
            if (push) begin
                wr_ptr_reg <= PTR_W'((wr_ptr_reg + 1) % FIFO_DEPTH);
            end
            if (pop) begin
                rd_ptr_reg <= PTR_W'((rd_ptr_reg + 1) % FIFO_DEPTH);
            end
            count_reg    <= count_reg + (push ? ONE_C : '0)
                                      - (pop ? ONE_C : '0);
            head_new_reg <= overwrite || (pop && count_reg > ONE_C)
                            || (push && (count_reg == '0
                                || (pop && count_reg == ONE_C)));
        end
    end

    logic [2:0] head_flags;
    logic [2:0] flag_set;

    assign head_flags = flag_mem[rd_ptr_reg];
    // flags revealed as character becomes head
    assign flag_set   = (head_new_reg && count_reg != '0)
                        ? head_flags : 3'h0;

    // status read clears; a new set wins
    always_ff @(posedge clock) begin
        if (!nrst) begin
            brk_reg <= 1'b0;
            fe_reg  <= 1'b0;
            pe_reg  <= 1'b0;
            oe_reg  <= 1'b0;
        end else begin
            brk_reg <= (brk_reg && !status_rd) || flag_set[2];
            fe_reg  <= (fe_reg && !status_rd) || flag_set[1];
            pe_reg  <= (pe_reg && !status_rd) || flag_set[0];
            oe_reg  <= (oe_reg && !status_rd) || overrun;
        end
    end

    logic [INT_W-1:0] int_set;

    assign int_set[INT_RX]   = push;
    assign int_set[INT_LINE] = overrun || (flag_set != 3'h0);

    always_ff @(posedge clock) begin
        if (!nrst) begin
            int_st_reg <= '0;
            irq        <= 1'b0;
        end else begin
            if (wr_stb && addr == ADDR_INT_STAT) begin
                int_st_reg <= (int_st_reg & ~wdata[INT_W-1:0]) | int_set;
            end else begin
                int_st_reg <= int_st_reg | int_set;
            end
            irq <= |(int_st_reg & int_mask_reg);
        end
    end

    logic [REG_W-1:0] status_word;

    always_comb begin
        status_word                = '0;
        status_word[LS_DATA_READY] = count_reg != '0;
        status_word[LS_OVERRUN]    = oe_reg;
        status_word[LS_PARITY_ERR] = pe_reg;
        status_word[LS_FRAME_ERR]  = fe_reg;
        status_word[LS_BREAK]      = brk_reg;
    end

    // Unmapped or idle reads return zero
    always_ff @(posedge clock) begin
        if (!nrst || !rd_stb) begin
            rdata <= '0;
        end else if (addr == ADDR_RX_BUF) begin
            rdata <= (count_reg != '0)
                     ? {8'h00, data_mem[rd_ptr_reg]} : '0;
        end else if (addr == ADDR_LINE_STAT) begin
            rdata <= status_word;
        end else if (addr == ADDR_CTRL) begin
            rdata <= {{(REG_W-CT_W){1'b0}}, ctrl_reg};
        end else if (addr == ADDR_INT_STAT) begin
            rdata <= {{(REG_W-INT_W){1'b0}}, int_st_reg};
        end else if (addr == ADDR_INT_MASK) begin
            rdata <= {{(REG_W-INT_W){1'b0}}, int_mask_reg};
        end else if (addr == ADDR_DIVISOR) begin
            rdata <= div_reg;
        end else begin
            rdata <= '0;
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);

    sequence s_stop_bad;
        state_reg == ST_STOP && tick_reg && os_reg == OVS_LAST
        && !line && shift_reg != 8'h00;
    endsequence

    sequence s_break_seen;
        state_reg == ST_HOLD && !line && brk_now;
    endsequence

    property p_ready_view;
        status_rd |=> rdata[LS_DATA_READY] == ($past(count_reg) != '0);
    endproperty
    a_ready_view: assert property (p_ready_view)
        else $error("data ready bit disagrees with buffer count");

    property p_status_clear;
        status_rd && flag_set == 3'h0 && !overrun
        |=> !brk_reg && !fe_reg && !pe_reg && !oe_reg;
    endproperty
    a_status_clear: assert property (p_status_clear)
        else $error("status read left an error flag set");

    property p_break_implies;
        brk_reg |-> fe_reg && pe_reg;
    endproperty
    a_break_implies: assert property (p_break_implies)
        else $error("break flag without framing and parity flags");

    property p_break_char;
        s_break_seen |=> ld_reg && ld_brk_reg && ld_data_reg == 8'h00
                         && state_reg == ST_BRK_WAIT;
    endproperty
    a_break_char: assert property (p_break_char)
        else $error("break did not load one zero character");

    property p_break_wait;
        state_reg == ST_BRK_WAIT && !line |=> state_reg == ST_BRK_WAIT
                                             && !ld_reg;
    endproperty
    a_break_wait: assert property (p_break_wait)
        else $error("receiver left break wait while line low");

    property p_resync;
        s_stop_bad |=> state_reg == ST_DATA && ld_reg && ld_fe_reg
                       && idx_reg == 3'h0;
    endproperty
    a_resync: assert property (p_resync)
        else $error("no resync after framing error");

    property p_overrun_plain;
        ld_reg && !fifo_en && count_reg != '0 && !pop && !flush
        |=> oe_reg && count_reg == ONE_C;
    endproperty
    a_overrun_plain: assert property (p_overrun_plain)
        else $error("non-fifo overrun not flagged or count wrong");

    property p_overrun_fifo;
        ld_reg && fifo_en && count_reg == DEPTH_C && !pop && !flush
        |=> oe_reg && count_reg == DEPTH_C;
    endproperty
    a_overrun_fifo: assert property (p_overrun_fifo)
        else $error("fifo overrun not flagged or fifo changed");

    property p_parity_gate;
        ld_reg && ld_pe_reg && !ld_brk_reg |-> par_en;
    endproperty
    a_parity_gate: assert property (p_parity_gate)
        else $error("parity error with parity disabled");

    property p_ready_clear;
        pop && count_reg == ONE_C && !push |=> count_reg == '0;
    endproperty
    a_ready_clear: assert property (p_ready_clear)
        else $error("data ready did not clear on last read");
endmodule

// file: urx_pkg.sv
package urx_pkg;

    // Register port
    localparam int          ADDR_W          = 3;
    localparam int          REG_W           = 16;
    localparam logic [2:0]  ADDR_RX_BUF     = 3'h0;
    localparam logic [2:0]  ADDR_LINE_STAT  = 3'h1;
    localparam logic [2:0]  ADDR_CTRL       = 3'h2;
    localparam logic [2:0]  ADDR_INT_STAT   = 3'h3;
    localparam logic [2:0]  ADDR_INT_MASK   = 3'h4;
    localparam logic [2:0]  ADDR_DIVISOR    = 3'h5;

    // Line status fields
    localparam int          LS_DATA_READY   = 0;
    localparam int          LS_OVERRUN      = 1;
    localparam int          LS_PARITY_ERR   = 2;
    localparam int          LS_FRAME_ERR    = 3;
    localparam int          LS_BREAK        = 4;

    // Control fields
    localparam int          CT_FIFO_EN      = 0;
    localparam int          CT_PARITY_EN    = 1;
    localparam int          CT_PARITY_EVEN  = 2;
    localparam int          CT_IR_MODE      = 3;
    localparam int          CT_DLEN_LO      = 4;
    localparam int          CT_STOP2        = 6;
    localparam int          CT_W            = 7;
    localparam logic [6:0]  CTRL_RESET      = 7'h30;
    localparam logic [15:0] DIV_RESET       = 16'h0001;

    // Interrupt fields
    localparam int          INT_RX          = 0;
    localparam int          INT_LINE        = 1;
    localparam int          INT_W           = 2;

    // Oversampling and timing
    localparam logic [3:0]  OVS_MID         = 4'h7;
    localparam logic [3:0]  OVS_LAST        = 4'hF;
    localparam logic [3:0]  MIN_DATA_BITS   = 4'h5;
    localparam logic [4:0]  IR_HOLD_TICKS   = 5'h10;
    localparam logic [7:0]  LOW_CNT_MAX     = 8'hFF;

    typedef enum logic [2:0] {
        ST_IDLE     = 3'b000,
        ST_START    = 3'b001,
        ST_DATA     = 3'b010,
        ST_PARITY   = 3'b011,
        ST_STOP     = 3'b100,
        ST_HOLD     = 3'b101,
        ST_BRK_WAIT = 3'b110
    } urx_state_t;

endpackage

// file: urx_sync.sv
`timescale 1ns/1ps
module urx_sync (
    // Clock and reset
    input  wire logic clock,
    input  wire logic nrst,
    // Level
    input  wire logic d,
    output logic      q
);
    logic meta_reg;

    // Idle line level is high
    always_ff @(posedge clock) begin
        if (!nrst) begin
            meta_reg <= 1'b1;
            q        <= 1'b1;
        end else begin
            meta_reg <= d;
            q        <= meta_reg;
        end
    end
endmodule

// file: urx_tx_model.sv
`timescale 1ns/1ps
// Far-end transmitter, 16 clocks a bit at divisor 1
module urx_tx_model (
    // Clock
    input  wire logic clock,
    // Receive lines
    output logic      serial_in,
    output logic      ir_in
);
    logic line   = 1'b1;
    logic ir_sel = 1'b0;
    // Unused line stays at idle high
    assign serial_in = ir_sel ? 1'b1 : line;
    assign ir_in     = ir_sel ? line : 1'b1;
    task automatic hold(input logic v, input int n);
        line <= v;
        repeat (n) @(posedge clock);
    endtask
    task automatic send(input logic [7:0] d, input logic parity_enable_bit,
                        input logic par, input logic stop);
        hold(1'b0, 16);
        for (int i = 0; i < 8; i++) hold(d[i], 16);
        if (parity_enable_bit) hold(par, 16);
        hold(stop, 16);
        hold(1'b1, 200);
    endtask
    // Short low pulses, close enough to read as one long low
    task automatic ir_brk(input int n);
        repeat (n) begin
            hold(1'b0, 4);
            hold(1'b1, 12);
        end
        hold(1'b1, 200);
    endtask
    task automatic brk(input int n);
        hold(1'b0, n);
        hold(1'b1, 200);
    endtask
endmodule

// file: urx_line_status_tb.sv
`timescale 1ns/1ps
module urx_line_status_tb import urx_pkg::*; ();
    logic              clock  = 1'b0;
    logic              nrst   = 1'b0;
    logic [ADDR_W-1:0] addr   = '0;
    logic [REG_W-1:0]  wdata  = '0;
    logic              wr_stb = 1'b0;
    logic              rd_stb = 1'b0;
    logic              rd_d   = 1'b0;
    logic [REG_W-1:0]  rdata;
    logic              serial_in;
    logic              ir_in;
    logic              irq;
    logic [REG_W-1:0]  expq[$];
    logic [7:0]        a;
    logic [7:0]        b;
    int                n_errors = 0;
    int                checks   = 0;
    int                seed     = 1;
    int                cyc      = 0;

    always #2.5 clock = ~clock;

    // Depth 2 so the full-FIFO case is cheap to reach
    urx_line_status #(.FIFO_DEPTH(2)) dut (
        .clock(clock), .nrst(nrst), .addr(addr), .wdata(wdata),
        .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
        .serial_in(serial_in), .ir_in(ir_in), .irq(irq));
    urx_tx_model tx (.clock(clock), .serial_in(serial_in), .ir_in(ir_in));

    task automatic chk(input logic [REG_W-1:0] got, input logic [REG_W-1:0] e);
        checks++;
        if (got !== e) begin
            n_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, e);
        end
    endtask

    task automatic end_sim();
        $display("checks=%0d n_errors=%0d", checks, n_errors);
        if (n_errors == 0 && checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // Read data stands only in the cycle after the strobe
    always @(posedge clock) begin
        if (rd_d) chk(rdata, expq.pop_front());
        rd_d <= rd_stb;
        cyc  <= cyc + 1;
        if (cyc > 50000) begin
            n_errors++;
            end_sim();
        end
    end

    task automatic wr(input logic [ADDR_W-1:0] ad, input logic [REG_W-1:0] d);
        @(posedge clock);
        addr   <= ad;
        wdata  <= d;
        wr_stb <= 1'b1;
        @(posedge clock);
        wr_stb <= 1'b0;
    endtask

    task automatic rd(input logic [ADDR_W-1:0] ad, input logic [REG_W-1:0] e);
        expq.push_back(e);
        @(posedge clock);
        addr   <= ad;
        rd_stb <= 1'b1;
        @(posedge clock);
        rd_stb <= 1'b0;
    endtask

    task automatic wait_irq();
        int n;
        n = 0;
        while (irq !== 1'b1 && n < 400) begin
            @(posedge clock);
            n++;
        end
        chk(16'(irq), 16'h0001);
        if (n == 400) end_sim();
    endtask

    initial begin
        repeat (6) @(posedge clock);
        nrst <= 1'b1;
        rd(ADDR_CTRL, 16'h0030);
        rd(ADDR_DIVISOR, 16'h0001);
        wr(ADDR_DIVISOR, 16'h00A5);
        rd(ADDR_DIVISOR, 16'h00A5);
        wr(ADDR_DIVISOR, 16'h0001);
        rd(ADDR_LINE_STAT, 16'h0000);
        rd(3'h7, 16'h0000);
        wr(ADDR_INT_MASK, 16'h0003);
        a = 8'($random(seed));
        tx.send(a, 1'b0, 1'b0, 1'b1);
        wait_irq();
        rd(ADDR_INT_STAT, 16'h0001);
        rd(ADDR_INT_MASK, 16'h0003);
        rd(ADDR_LINE_STAT, 16'h0001);
        rd(ADDR_RX_BUF, {8'h00, a});
        rd(ADDR_LINE_STAT, 16'h0000);
        wr(ADDR_INT_STAT, 16'h0003);
        wr(ADDR_INT_MASK, 16'h0000);
        repeat (3) @(posedge clock);
        chk(16'(irq), 16'h0000);
        rd(ADDR_INT_STAT, 16'h0000);
        a = 8'($random(seed));
        b = 8'($random(seed));
        tx.send(a, 1'b0, 1'b0, 1'b1);
        tx.send(b, 1'b0, 1'b0, 1'b1);
        chk(16'(irq), 16'h0000);
        rd(ADDR_INT_STAT, 16'h0003);
        rd(ADDR_LINE_STAT, 16'h0003);
        rd(ADDR_LINE_STAT, 16'h0001);
        rd(ADDR_RX_BUF, {8'h00, b});
        a = 8'($random(seed)) | 8'h01;
        tx.send(a, 1'b0, 1'b0, 1'b0);
        rd(ADDR_LINE_STAT, 16'h000B);
        rd(ADDR_RX_BUF, 16'h00FF);
        tx.brk(400);
        rd(ADDR_LINE_STAT, 16'h001D);
        rd(ADDR_LINE_STAT, 16'h0001);
        rd(ADDR_RX_BUF, 16'h0000);
        rd(ADDR_LINE_STAT, 16'h0000);
        wr(ADDR_CTRL, 16'h0036);
        a = 8'($random(seed));
        tx.send(a, 1'b1, ~^a, 1'b1);
        rd(ADDR_LINE_STAT, 16'h0005);
        rd(ADDR_RX_BUF, {8'h00, a});
        tx.send(a, 1'b1, ^a, 1'b1);
        rd(ADDR_LINE_STAT, 16'h0001);
        rd(ADDR_RX_BUF, {8'h00, a});
        wr(ADDR_CTRL, 16'h0032);
        tx.send(a, 1'b1, ^a, 1'b1);
        rd(ADDR_LINE_STAT, 16'h0005);
        rd(ADDR_RX_BUF, {8'h00, a});
        wr(ADDR_CTRL, 16'h0020);
        tx.send(a | 8'h80, 1'b0, 1'b0, 1'b1);
        rd(ADDR_RX_BUF, {9'h000, a[6:0]});
        rd(ADDR_LINE_STAT, 16'h0000);
        wr(ADDR_CTRL, 16'h0031);
        a = 8'($random(seed));
        b = 8'($random(seed));
        tx.send(a, 1'b0, 1'b0, 1'b1);
        tx.send(b, 1'b0, 1'b0, 1'b1);
        tx.send(8'($random(seed)), 1'b0, 1'b0, 1'b1);
        rd(ADDR_LINE_STAT, 16'h0003);
        rd(ADDR_RX_BUF, {8'h00, a});
        rd(ADDR_LINE_STAT, 16'h0001);
        rd(ADDR_RX_BUF, {8'h00, b});
        rd(ADDR_LINE_STAT, 16'h0000);
        tx.send(a, 1'b0, 1'b0, 1'b1);
        tx.brk(400);
        rd(ADDR_LINE_STAT, 16'h0001);
        rd(ADDR_RX_BUF, {8'h00, a});
        repeat (4) @(posedge clock);
        rd(ADDR_LINE_STAT, 16'h001D);
        rd(ADDR_RX_BUF, 16'h0000);
        wr(ADDR_CTRL, 16'h0038);
        tx.ir_sel <= 1'b1;
        tx.ir_brk(25);
        rd(ADDR_LINE_STAT, 16'h001D);
        rd(ADDR_RX_BUF, 16'h0000);
        repeat (3) @(posedge clock);
        end_sim();
    end
endmodule
